/* hw/aes_pkg.sv */
// Package for the alarm and error status object bank
package aes_pkg;

	// ------------------------------------------------------------
	// Register indices, one word each; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [15:0] IDX_CLEAR_HIST = 16'h2a40;
	localparam logic [15:0] IDX_CUR_ALARM = 16'h2a41;
	localparam logic [15:0] IDX_CUR_ALARM_SHORT = 16'h2a42;
	localparam logic [15:0] IDX_PT_ERR = 16'h2a43;
	localparam logic [15:0] IDX_PAR_ERR_TOTAL = 16'h2a44;
	localparam logic [15:0] IDX_PAR_ERR_LIST = 16'h2a45;
	// Sub-objects and block registers placed after the objects
	localparam logic [15:0] IDX_PT_ERR_NUM = 16'h2a50;
	localparam logic [15:0] IDX_PT_ERR_FACTOR = 16'h2a51;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h2a52;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h2a53;
	localparam logic [15:0] IDX_HIST_CLEARED = 16'h2a54;
	localparam logic [15:0] IDX_PAR_ENTRY_BASE = 16'h2a60;
	localparam int ENTRY_NUM = 32;

	// ------------------------------------------------------------
	// Values and fields
	// ------------------------------------------------------------
	localparam logic [15:0] CLEAR_CODE = 16'h1ea5;
	localparam logic [7:0] PT_ERR_SUBCOUNT = 8'h02;
	localparam logic [7:0] PAR_ENTRY_COUNT = 8'h20;
	localparam logic [31:0] PT_FACTOR_MASK = 32'h0000_007d;
	localparam logic [15:0] PAR_TOTAL_MAX = 16'h01f4;
	localparam logic [7:0] PT_NUM_MAX = 8'hff;
	localparam logic [3:0] GROUP_USER_MAX = 4'h5;
	localparam logic [3:0] GROUP_MAKER_MAX = 4'h9;

	// Interrupt status bits
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_PT_ERR = 1;
	localparam int IRQ_PAR_ERR = 2;
	localparam int IRQ_HIST_CLR = 3;
	localparam int IRQ_W = 4;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] number;
		logic [15:0] detail;
	} aes_alarm_t;

	typedef struct packed {
		logic [7:0] group;
		logic [7:0] number;
	} aes_par_entry_t;

	typedef struct packed {
		logic [15:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} aes_apb_req_t;

endpackage : aes_pkg

/* hw/aes_status_bank.sv */
// APB register bank for alarm and error status objects
//
// Operation
// - Writing 1EA5h clears the alarm history
// - 32-bit alarm: detail low, number high
// - No alarm reads as all zero
// - 16-bit alarm: detail low byte, number high
// - Failing point table number, up to FFh
// - Point table factor bits, reserved bits zero
// - Entries: number low byte, group high byte
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

module aes_status_bank #(
	parameter int ENTRIES = aes_pkg::ENTRY_NUM
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// APB slave
	input wire logic [15:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Alarm source
	input wire logic alarm_active,
	input wire logic [7:0] alarm_number,
	input wire logic [7:0] alarm_detail,
	input wire logic parameter_fault_alarm,
	// Point table error source
	input wire logic pt_err_valid,
	input wire logic [7:0] pt_err_table,
	input wire logic [31:0] pt_err_factor,
	// Parameter error source
	input wire logic [15:0] par_err_total,
	input wire logic par_entry_we,
	input wire logic [4:0] par_entry_idx,
	input wire logic [15:0] par_entry_data,
	// History control and interrupt
	output logic hist_clear,
	output logic irq
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (ENTRIES != aes_pkg::ENTRY_NUM) begin : g_bad_depth
		$error("Parameter error list depth must be 32");
	end

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	aes_pkg::aes_alarm_t alarm_q;
	logic [15:0] pt_num_q;
	logic [31:0] pt_factor_q;
	logic [15:0] par_total_q;
	aes_pkg::aes_par_entry_t entry_q [ENTRIES];
	logic [aes_pkg::IRQ_W-1:0] irq_status_q;
	logic [aes_pkg::IRQ_W-1:0] irq_mask_q;
	logic [15:0] hist_clear_cnt_q;
	logic alarm_prev_q;
	logic pt_prev_q;
	logic par_prev_q;
	logic hist_clear_q;
	logic [31:0] prdata_q;
	logic pslverr_q;

	logic wr_en;
	logic rd_en;
	logic rd_hit;
	logic [31:0] rd_val;
	logic [aes_pkg::IRQ_W-1:0] irq_event;
	logic status_read;
	logic [4:0] entry_sel;
	logic entry_hit;
	logic [15:0] entry_off;
	logic [3:0] group_code;
	logic [15:0] reg_idx;
	logic addr_aligned;
	logic sel_clear;
	logic sel_status;
	logic sel_mask;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// One object per word, so the byte address is four times the index
	assign reg_idx = {2'b00, paddr[15:2]};
	assign addr_aligned = paddr[1:0] == 2'b00;
	assign sel_clear = addr_aligned && reg_idx == aes_pkg::IDX_CLEAR_HIST;
	assign sel_status = addr_aligned && reg_idx == aes_pkg::IDX_IRQ_STATUS;
	assign sel_mask = addr_aligned && reg_idx == aes_pkg::IDX_IRQ_MASK;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign entry_off = reg_idx - aes_pkg::IDX_PAR_ENTRY_BASE;
	assign entry_hit = (reg_idx >= aes_pkg::IDX_PAR_ENTRY_BASE)
		&& (entry_off < 16'(ENTRIES));
	assign entry_sel = entry_off[4:0];

	// ------------------------------------------------------------
	// Current alarm capture
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			alarm_q <= '0;
		end else if (alarm_active) begin
			alarm_q.number <= {8'h00, alarm_number};
			alarm_q.detail <= {8'h00, alarm_detail};
		end else begin
			alarm_q <= '0;
		end
	end

	// ------------------------------------------------------------
	// Point table error capture
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pt_num_q <= '0;
			pt_factor_q <= '0;
		end else if (pt_err_valid) begin
			pt_num_q <= {8'h00, pt_err_table};
			pt_factor_q <= pt_err_factor & aes_pkg::PT_FACTOR_MASK;
		end
	end

	// ------------------------------------------------------------
	// Parameter error capture
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			par_total_q <= '0;
		end else if (!parameter_fault_alarm) begin
			par_total_q <= '0;
		end else if (par_err_total > aes_pkg::PAR_TOTAL_MAX) begin
			par_total_q <= aes_pkg::PAR_TOTAL_MAX;
		end else begin
			par_total_q <= par_err_total;
		end
	end

	assign group_code = par_entry_data[11:8];

	generate
		for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					entry_q[i] <= '0;
				end else if (par_entry_we && par_entry_idx == 5'(i)) begin
					// Only group codes up to the maker range are stored
					if (par_entry_data[15:12] == 4'h0
						&& group_code <= aes_pkg::GROUP_MAKER_MAX) begin
						entry_q[i] <= par_entry_data;
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Clear history command
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			hist_clear_q <= 1'b0;
			hist_clear_cnt_q <= '0;
		end else if (wr_en && sel_clear && pwdata[15:0] == aes_pkg::CLEAR_CODE) begin
			hist_clear_q <= 1'b1;
			hist_clear_cnt_q <= hist_clear_cnt_q + 16'h0001;
		end else begin
			hist_clear_q <= 1'b0;
		end
	end

	assign hist_clear = hist_clear_q;

	// ------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------
	// Previous levels reset to the idle level, so no false edge after reset
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			alarm_prev_q <= 1'b0;
		end else begin
			alarm_prev_q <= alarm_active;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pt_prev_q <= 1'b0;
		end else begin
			pt_prev_q <= pt_err_valid;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			par_prev_q <= 1'b0;
		end else begin
			par_prev_q <= parameter_fault_alarm;
		end
	end

	always_comb begin
		irq_event = '0;
		irq_event[aes_pkg::IRQ_ALARM] = alarm_active && !alarm_prev_q;
		irq_event[aes_pkg::IRQ_PT_ERR] = pt_err_valid && !pt_prev_q;
		irq_event[aes_pkg::IRQ_PAR_ERR] = parameter_fault_alarm && !par_prev_q;
		irq_event[aes_pkg::IRQ_HIST_CLR] = hist_clear_q;
	end

	assign status_read = rd_en && sel_status;

	// Read clears only the bits handed out at setup; new events win
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_status_q <= '0;
		end else if (status_read) begin
			irq_status_q <= (irq_status_q & ~prdata_q[aes_pkg::IRQ_W-1:0]) | irq_event;
		end else begin
			irq_status_q <= irq_status_q | irq_event;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_mask_q <= '0;
		end else if (wr_en && sel_mask) begin
			irq_mask_q <= pwdata[aes_pkg::IRQ_W-1:0];
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		if (entry_hit) begin
			rd_val = {16'h0000, entry_q[entry_sel]};
		end else begin
			case (reg_idx)
				aes_pkg::IDX_CUR_ALARM: begin
					rd_val = alarm_q;
				end
				aes_pkg::IDX_CUR_ALARM_SHORT: begin
					rd_val = {16'h0000, alarm_q.number[7:0], alarm_q.detail[7:0]};
				end
				aes_pkg::IDX_PT_ERR: begin
					rd_val = {24'h000000, aes_pkg::PT_ERR_SUBCOUNT};
				end
				aes_pkg::IDX_PT_ERR_NUM: begin
					rd_val = {16'h0000, pt_num_q};
				end
				aes_pkg::IDX_PT_ERR_FACTOR: begin
					rd_val = pt_factor_q;
				end
				aes_pkg::IDX_PAR_ERR_TOTAL: begin
					rd_val = {16'h0000, par_total_q};
				end
				aes_pkg::IDX_PAR_ERR_LIST: begin
					rd_val = {24'h000000, aes_pkg::PAR_ENTRY_COUNT};
				end
				aes_pkg::IDX_IRQ_STATUS: begin
					rd_val = {28'h0000000, irq_status_q};
				end
				aes_pkg::IDX_IRQ_MASK: begin
					rd_val = {28'h0000000, irq_mask_q};
				end
				aes_pkg::IDX_HIST_CLEARED: begin
					rd_val = {16'h0000, hist_clear_cnt_q};
				end
				default: begin
					rd_hit = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// APB response
	// ------------------------------------------------------------
	logic wr_ok;
	assign wr_ok = sel_clear || sel_mask;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prdata_q <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= rd_val;
		end
	end

	always_comb begin
		pslverr_q = 1'b0;
		if (psel && penable) begin
			pslverr_q = pwrite ? !wr_ok : (!rd_hit || !addr_aligned || sel_clear);
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = pslverr_q;

endmodule : aes_status_bank

/* testbench/aes_apb_master.sv */
// Bus master model for the status bank
`timescale 1ns/1ps
module aes_apb_master (
	// Clock
	input wire logic clock,
	// Bus
	output logic [15:0] paddr = 16'h0,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [31:0] pwdata = 32'h0,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// One transfer, idle cycle first so calls never collide
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clock);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		penable <= 1'b0;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : aes_apb_master

/* testbench/aes_status_bank_chk.sv */
// Port checker for the status bank
`timescale 1ns/1ps
module aes_status_bank_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Bus
	input wire logic [15:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Alarm and history
	input wire logic alarm_active,
	input wire logic [7:0] alarm_number,
	input wire logic [7:0] alarm_detail,
	input wire logic hist_clear
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic wr;
	logic su;
	logic clr_ok;
	logic clr_bad;
	assign wr = psel && penable && pwrite;
	assign su = psel && !penable;
	// Clear object at byte address four times its index
	assign clr_ok = wr && paddr == 16'ha900 && pwdata[15:0] == 16'h1ea5;
	assign clr_bad = wr && paddr == 16'ha900 && pwdata[15:0] != 16'h1ea5;
	property p_idle(a);
		!alarm_active [*2] ##0 (su && paddr == a) |=> prdata == 32'h0;
	endproperty
	sequence s_live(a);
		alarm_active [*2] ##0 (su && paddr == a && $stable(alarm_number) && $stable(alarm_detail));
	endsequence
	chk_clear_cause: assert property (hist_clear |-> $past(clr_ok))
		else $error("history pulse without clear code");
	chk_clear_pulse: assert property (clr_ok |=> hist_clear)
		else $error("clear code gave no pulse");
	chk_clear_single: assert property (hist_clear |=> !hist_clear)
		else $error("history pulse too long");
	chk_clear_ignore: assert property (clr_bad |=> !hist_clear)
		else $error("wrong code cleared history");
	chk_idle_long: assert property (p_idle(16'ha904))
		else $error("idle alarm word not zero");
	chk_idle_short: assert property (p_idle(16'ha908))
		else $error("idle short alarm not zero");
	chk_alarm_long: assert property (s_live(16'ha904) |=>
		prdata == {8'h00, $past(alarm_number), 8'h00, $past(alarm_detail)})
		else $error("alarm word layout wrong");
	chk_alarm_short: assert property (s_live(16'ha908) |=>
		prdata == {16'h0, $past(alarm_number), $past(alarm_detail)})
		else $error("short alarm layout wrong");
	chk_list_count: assert property (su && paddr == 16'ha914 |=> prdata == 32'h20)
		else $error("list count not 32");
	cover property (hist_clear);
	cover property (s_live(16'ha904));
	cover property (clr_bad);
endmodule : aes_status_bank_chk

bind aes_status_bank aes_status_bank_chk u_aes_status_bank_chk (.*);

/* testbench/alarm_error_status_objects_bench.sv */
// Self-checking bench for the status bank
`timescale 1ns/1ps
module alarm_error_status_objects_bench;
	typedef struct {logic [15:0] a; logic [31:0] e;} aes_row_t;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] paddr;
	logic psel, penable, pwrite, pready, pslverr, hist_clear, irq, er;
	logic [31:0] pwdata, prdata, rd;
	logic alarm_active = 1'b0;
	logic parameter_fault_alarm = 1'b0;
	logic pt_err_valid = 1'b0;
	logic par_entry_we = 1'b0;
	logic [7:0] alarm_number = 8'h00, alarm_detail = 8'h00, pt_err_table = 8'h00;
	logic [31:0] pt_err_factor = 32'h0;
	logic [15:0] par_err_total = 16'h0, par_entry_data = 16'h0;
	logic [4:0] par_entry_idx = 5'h00;
	int num_errors = 0, num_checks = 0, cyc = 0;
	aes_row_t rows[10] = '{'{16'h2a41, 32'h00250003}, '{16'h2a42, 32'h2503},
		'{16'h2a43, 32'h2}, '{16'h2a50, 32'hff}, '{16'h2a51, 32'h7d}, '{16'h2a44, 32'h1f4},
		'{16'h2a45, 32'h20}, '{16'h2a60, 32'h512}, '{16'h2a7f, 32'h907}, '{16'h2a61, 32'h0}};

	always #5 clock = ~clock;
	aes_status_bank u_aes_status_bank (.*);
	aes_apb_master u_aes_apb_master (.*);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic rdc(input logic [15:0] a, input logic [31:0] e);
		u_aes_apb_master.xfer(1'b0, {a[13:0], 2'b00}, 32'h0, rd, er);
		check(rd, e);
	endtask : rdc
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		u_aes_apb_master.xfer(1'b1, {a[13:0], 2'b00}, d, rd, er);
	endtask : wr
	task automatic give_verdict;
		$display("Checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict

	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			give_verdict();
		end
	end

	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		check({29'h0, pready, irq, hist_clear}, 32'h4);
		rdc(16'h2a41, 32'h0);
		rdc(16'h2a42, 32'h0);
		$display("Reset test done");
		alarm_active <= 1'b1;
		alarm_number <= 8'h25;
		alarm_detail <= 8'h03;
		pt_err_valid <= 1'b1;
		pt_err_table <= 8'hff;
		pt_err_factor <= 32'hffffffff;
		parameter_fault_alarm <= 1'b1;
		par_err_total <= 16'h0300;
		par_entry_we <= 1'b1;
		par_entry_data <= 16'h0512;
		@(posedge clock);
		pt_err_valid <= 1'b0;
		par_entry_idx <= 5'h1f;
		par_entry_data <= 16'h0907;
		@(posedge clock);
		par_entry_idx <= 5'h01;
		par_entry_data <= 16'h0a01;
		@(posedge clock);
		par_entry_we <= 1'b0;
		foreach (rows[i]) rdc(rows[i].a, rows[i].e);
		$display("Table test done");
		check({31'h0, irq}, 32'h0);
		wr(16'h2a53, 32'hf);
		rdc(16'h2a53, 32'hf);
		repeat (2) @(posedge clock);
		check({31'h0, irq}, 32'h1);
		rdc(16'h2a52, 32'h7);
		repeat (2) @(posedge clock);
		check({31'h0, irq}, 32'h0);
		rdc(16'h2a52, 32'h0);
		$display("Interrupt test done");
		wr(16'h2a40, 32'h1234);
		@(negedge clock);
		check({31'h0, hist_clear}, 32'h0);
		rdc(16'h2a54, 32'h0);
		rdc(16'h2a52, 32'h0);
		wr(16'h2a40, 32'h1ea5);
		@(negedge clock);
		check({31'h0, hist_clear}, 32'h1);
		rdc(16'h2a54, 32'h1);
		check({31'h0, irq}, 32'h1);
		rdc(16'h2a52, 32'h8);
		$display("Clear test done");
		wr(16'h2a41, 32'hffff);
		check({31'h0, er}, 32'h1);
		rdc(16'h2a41, 32'h00250003);
		u_aes_apb_master.xfer(1'b0, 16'h3000, 32'h0, rd, er);
		check({31'h0, er}, 32'h1);
		u_aes_apb_master.xfer(1'b0, 16'ha905, 32'h0, rd, er);
		check({31'h0, er}, 32'h1);
		alarm_active <= 1'b0;
		parameter_fault_alarm <= 1'b0;
		repeat (2) @(posedge clock);
		rdc(16'h2a41, 32'h0);
		rdc(16'h2a42, 32'h0);
		rdc(16'h2a44, 32'h0);
		$display("Refusal test done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		check({29'h0, pready, irq, hist_clear}, 32'h4);
		rdc(16'h2a53, 32'h0);
		rdc(16'h2a54, 32'h0);
		rdc(16'h2a50, 32'h0);
		rdc(16'h2a60, 32'h0);
		$display("Mid-run reset test done");
		give_verdict();
	end
endmodule : alarm_error_status_objects_bench
